// >>> verilog/tcd_map.svh
// Purpose: Register offsets, field positions and burst constants of the DMA engine
// Assumes: APB byte addresses, AXI data path 64 bits wide
// Notes:   Included by its bare name
`ifndef TCD_MAP_SVH
`define TCD_MAP_SVH

`define TCD_OFS_CTRL      12'h000
`define TCD_OFS_HOST_ADDR 12'h004
`define TCD_OFS_DDR_ADDR  12'h008
`define TCD_OFS_STATUS    12'h00C
`define TCD_OFS_CYCLES    12'h010

`define TCD_CTRL_START    8
`define TCD_CTRL_MODE_HI  2

`define TCD_AXLEN         8'h0F
`define TCD_AXSIZE        3'h3
`define TCD_AXBURST       2'h1
`define TCD_WSTRB         8'hFF
`define TCD_LAST_BEAT     4'hF
`define TCD_BURSTS        6'h20
`define TCD_BURST_SHIFT   7
`define TCD_ALL_FULL      32'hFFFF_FFFF
`define TCD_NONE_FULL     32'h0000_0000
`define TCD_RESP_OKAY     2'h0
`define TCD_ZERO32        32'h0000_0000
`define TCD_PORT_HST      1'h0
`define TCD_PORT_MEM      1'h1

`endif

// >>> verilog/tcd_pkg.sv
// Purpose: Types shared by the two channel burst DMA engine
// Assumes: Constants come from tcd_map.svh
// Notes:   State of the top module is one packed struct
package tcd_pkg;

	typedef enum logic [2:0] {
		MODE_HOST_TO_BUF = 3'b000,
		MODE_HOST_TO_MEM = 3'b001,
		MODE_BUF_TO_MEM  = 3'b010,
		MODE_BUF_TO_HOST = 3'b011,
		MODE_MEM_TO_HOST = 3'b100,
		MODE_MEM_TO_BUF  = 3'b101
	} tcd_mode_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_ADDR = 2'b01,
		RD_DATA = 2'b10
	} tcd_rd_t;

	typedef enum logic [2:0] {
		WR_IDLE  = 3'b000,
		WR_ADDR  = 3'b001,
		WR_FETCH = 3'b010,
		WR_LOAD  = 3'b011,
		WR_BEAT  = 3'b100,
		WR_RESP  = 3'b101
	} tcd_wr_t;

	typedef struct packed {
		tcd_mode_t   mode;
		logic [31:0] host_addr;
		logic [31:0] ddr_addr;
		logic        busy;
		logic        done;
		logic        error;
		logic        chan;
		logic [31:0] cycles;
		tcd_rd_t     rd_state;
		logic        rd_port;
		logic [5:0]  rd_cnt;
		logic [3:0]  rd_beat;
		tcd_wr_t     wr_state;
		logic        wr_port;
		logic [5:0]  wr_cnt;
		logic [3:0]  wr_beat;
		logic [31:0] full_flags;
		logic [1:0]  arvalid;
		logic [1:0]  rready;
		logic [1:0]  awvalid;
		logic [1:0]  wvalid;
		logic [1:0]  bready;
		logic [31:0] araddr;
		logic [31:0] awaddr;
		logic [63:0] wdata;
		logic        wlast;
		logic [7:0]  axlen;
		logic [2:0]  axsize;
		logic [1:0]  axburst;
		logic [7:0]  wstrb;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} tcd_state_t;

endpackage : tcd_pkg

// >>> verilog/tcd_buffer_ram.sv
// Purpose: Dual port staging buffer RAM, 512 words of 64 bits (4 KB)
// Assumes: One clock, one write port and one read port
// Notes:   Read data appear from a register one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module tcd_buffer_ram (
	input  wire logic        clk_in,
	input  wire logic        we_in,
	input  wire logic [8:0]  waddr_in,
	input  wire logic [63:0] wdata_in,
	input  wire logic [8:0]  raddr_in,
	output var  logic [63:0] rdata_out
);
	logic [63:0] mem [512];
	logic [63:0] rdata_reg;

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_reg <= mem[raddr_in];
	end

	assign rdata_out = rdata_reg;
endmodule : tcd_buffer_ram
`default_nettype wire

// >>> verilog/tcd_dma_top.sv
// Purpose: Two channel burst DMA engine, APB registers, two AXI master ports
// Assumes: One clock; host port faces the PCIe AXI slave, mem port the DDR controller
// Notes:   One transfer runs at a time; read and write engines run concurrently
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.svh"
module tcd_dma_top
	import tcd_pkg::*;
(
	input  wire logic        REF_CLK_IN,
	input  wire logic        NRST_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output var  logic [31:0] PRDATA_OUT,
	output var  logic        PREADY_OUT,
	output var  logic        PSLVERR_OUT,
	output var  logic [31:0] HST_ARADDR_OUT,
	output var  logic [7:0]  HST_ARLEN_OUT,
	output var  logic [2:0]  HST_ARSIZE_OUT,
	output var  logic [1:0]  HST_ARBURST_OUT,
	output var  logic        HST_ARVALID_OUT,
	input  wire logic        HST_ARREADY_IN,
	input  wire logic [63:0] HST_RDATA_IN,
	input  wire logic [1:0]  HST_RRESP_IN,
	input  wire logic        HST_RLAST_IN,
	input  wire logic        HST_RVALID_IN,
	output var  logic        HST_RREADY_OUT,
	output var  logic [31:0] HST_AWADDR_OUT,
	output var  logic [7:0]  HST_AWLEN_OUT,
	output var  logic [2:0]  HST_AWSIZE_OUT,
	output var  logic [1:0]  HST_AWBURST_OUT,
	output var  logic        HST_AWVALID_OUT,
	input  wire logic        HST_AWREADY_IN,
	output var  logic [63:0] HST_WDATA_OUT,
	output var  logic [7:0]  HST_WSTRB_OUT,
	output var  logic        HST_WLAST_OUT,
	output var  logic        HST_WVALID_OUT,
	input  wire logic        HST_WREADY_IN,
	input  wire logic [1:0]  HST_BRESP_IN,
	input  wire logic        HST_BVALID_IN,
	output var  logic        HST_BREADY_OUT,
	output var  logic [31:0] MEM_ARADDR_OUT,
	output var  logic [7:0]  MEM_ARLEN_OUT,
	output var  logic [2:0]  MEM_ARSIZE_OUT,
	output var  logic [1:0]  MEM_ARBURST_OUT,
	output var  logic        MEM_ARVALID_OUT,
	input  wire logic        MEM_ARREADY_IN,
	input  wire logic [63:0] MEM_RDATA_IN,
	input  wire logic [1:0]  MEM_RRESP_IN,
	input  wire logic        MEM_RLAST_IN,
	input  wire logic        MEM_RVALID_IN,
	output var  logic        MEM_RREADY_OUT,
	output var  logic [31:0] MEM_AWADDR_OUT,
	output var  logic [7:0]  MEM_AWLEN_OUT,
	output var  logic [2:0]  MEM_AWSIZE_OUT,
	output var  logic [1:0]  MEM_AWBURST_OUT,
	output var  logic        MEM_AWVALID_OUT,
	input  wire logic        MEM_AWREADY_IN,
	output var  logic [63:0] MEM_WDATA_OUT,
	output var  logic [7:0]  MEM_WSTRB_OUT,
	output var  logic        MEM_WLAST_OUT,
	output var  logic        MEM_WVALID_OUT,
	input  wire logic        MEM_WREADY_IN,
	input  wire logic [1:0]  MEM_BRESP_IN,
	input  wire logic        MEM_BVALID_IN,
	output var  logic        MEM_BREADY_OUT
);
	tcd_state_t  st_reg;
	tcd_state_t  st_next;
	logic        ram_we;
	logic [8:0]  ram_waddr;
	logic [8:0]  ram_raddr;
	logic [63:0] ram_rdata;
	wire logic [1:0]  ar_ready = {MEM_ARREADY_IN, HST_ARREADY_IN};
	wire logic [1:0]  r_valid  = {MEM_RVALID_IN, HST_RVALID_IN};
	wire logic [1:0]  r_last   = {MEM_RLAST_IN, HST_RLAST_IN};
	wire logic [1:0]  aw_ready = {MEM_AWREADY_IN, HST_AWREADY_IN};
	wire logic [1:0]  w_ready  = {MEM_WREADY_IN, HST_WREADY_IN};
	wire logic [1:0]  b_valid  = {MEM_BVALID_IN, HST_BVALID_IN};
	wire logic [1:0]  r_bad    = {MEM_RRESP_IN != `TCD_RESP_OKAY, HST_RRESP_IN != `TCD_RESP_OKAY};
	wire logic [1:0]  b_bad    = {MEM_BRESP_IN != `TCD_RESP_OKAY, HST_BRESP_IN != `TCD_RESP_OKAY};
	wire logic [63:0] r_word   = st_reg.rd_port ? MEM_RDATA_IN : HST_RDATA_IN;
	logic        has_src;
	logic        has_dst;
	logic        src_port;
	logic        dst_port;
	logic        start_ok;
	// Route of the requested mode
	always_comb begin
		has_src  = (st_reg.mode != MODE_BUF_TO_MEM) && (st_reg.mode != MODE_BUF_TO_HOST);
		has_dst  = (st_reg.mode != MODE_HOST_TO_BUF) && (st_reg.mode != MODE_MEM_TO_BUF);
		src_port = (st_reg.mode == MODE_HOST_TO_BUF || st_reg.mode == MODE_HOST_TO_MEM)
			? `TCD_PORT_HST : `TCD_PORT_MEM;
		dst_port = (st_reg.mode == MODE_BUF_TO_MEM || st_reg.mode == MODE_HOST_TO_MEM)
			? `TCD_PORT_MEM : `TCD_PORT_HST;
		start_ok = !st_reg.busy && (st_reg.mode <= MODE_MEM_TO_BUF);
	end
	always_comb begin
		st_next           = st_reg;
		ram_we            = 1'b0;
		ram_waddr         = {st_reg.rd_cnt[4:0], st_reg.rd_beat};
		ram_raddr         = {st_reg.wr_cnt[4:0], st_reg.wr_beat};
		st_next.axlen     = `TCD_AXLEN;
		st_next.axsize    = `TCD_AXSIZE;
		st_next.axburst   = `TCD_AXBURST;
		st_next.wstrb     = `TCD_WSTRB;
		st_next.pready    = PSEL_IN && !PENABLE_IN;
		st_next.pslverr   = 1'b0;
		st_next.prdata    = `TCD_ZERO32;
		// APB setup cycle: capture read data for the access cycle
		if (PSEL_IN && !PENABLE_IN) begin
			case (PADDR_IN)
				`TCD_OFS_CTRL:      st_next.prdata = {29'h0000_0000, st_reg.mode};
				`TCD_OFS_HOST_ADDR: st_next.prdata = st_reg.host_addr;
				`TCD_OFS_DDR_ADDR:  st_next.prdata = st_reg.ddr_addr;
				`TCD_OFS_STATUS:    st_next.prdata = {28'h000_0000, st_reg.chan,
					st_reg.error, st_reg.done, st_reg.busy};
				`TCD_OFS_CYCLES:    st_next.prdata = st_reg.cycles;
				default:            st_next.pslverr = 1'b1;
			endcase
		end
		// APB write takes effect at the access edge; setup is locked while busy
		if (PSEL_IN && PENABLE_IN && st_reg.pready && PWRITE_IN && !st_reg.busy) begin
			case (PADDR_IN)
				`TCD_OFS_CTRL: begin
					if (!PWDATA_IN[`TCD_CTRL_START] &&
						PWDATA_IN[`TCD_CTRL_MODE_HI:0] <= MODE_MEM_TO_BUF) begin
						st_next.mode = tcd_mode_t'(PWDATA_IN[`TCD_CTRL_MODE_HI:0]);
					end
				end
				`TCD_OFS_HOST_ADDR: st_next.host_addr = PWDATA_IN;
				`TCD_OFS_DDR_ADDR:  st_next.ddr_addr = PWDATA_IN;
				default: ;
			endcase
		end
		// Start uses the setup already held, not a mode in the same write
		if (PSEL_IN && PENABLE_IN && st_reg.pready && PWRITE_IN && start_ok &&
			PADDR_IN == `TCD_OFS_CTRL && PWDATA_IN[`TCD_CTRL_START]) begin
			st_next.busy       = 1'b1;
			st_next.done       = 1'b0;
			st_next.error      = 1'b0;
			st_next.cycles     = `TCD_ZERO32;
			st_next.chan       = (st_reg.mode >= MODE_BUF_TO_HOST);
			st_next.rd_cnt     = has_src ? 6'h00 : `TCD_BURSTS;
			st_next.wr_cnt     = has_dst ? 6'h00 : `TCD_BURSTS;
			st_next.full_flags = has_src ? `TCD_NONE_FULL : `TCD_ALL_FULL;
		end
		// Timer and completion
		if (st_reg.busy) begin
			st_next.cycles = st_reg.cycles + 32'h0000_0001;
			if (st_reg.rd_cnt == `TCD_BURSTS && st_reg.wr_cnt == `TCD_BURSTS) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
		end
		// Read engine: source port into the buffer
		case (st_reg.rd_state)
			RD_IDLE: begin
				if (st_reg.busy && st_reg.rd_cnt != `TCD_BURSTS) begin
					st_next.rd_port          = src_port;
					st_next.arvalid[src_port] = 1'b1;
					st_next.araddr = (src_port == `TCD_PORT_HST ? st_reg.host_addr
						: st_reg.ddr_addr) + (32'(st_reg.rd_cnt) << `TCD_BURST_SHIFT);
					st_next.rd_beat          = 4'h0;
					st_next.rd_state         = RD_ADDR;
				end
			end
			RD_ADDR: begin
				if (ar_ready[st_reg.rd_port]) begin
					st_next.arvalid[st_reg.rd_port] = 1'b0;
					st_next.rready[st_reg.rd_port]  = 1'b1;
					st_next.rd_state                = RD_DATA;
				end
			end
			RD_DATA: begin
				if (r_valid[st_reg.rd_port]) begin
					ram_we          = 1'b1;
					st_next.rd_beat = st_reg.rd_beat + 4'h1;
					st_next.error   = st_next.error | r_bad[st_reg.rd_port];
					if (r_last[st_reg.rd_port] || st_reg.rd_beat == `TCD_LAST_BEAT) begin
						st_next.rready[st_reg.rd_port]         = 1'b0;
						st_next.full_flags[st_reg.rd_cnt[4:0]] = 1'b1;
						st_next.rd_cnt                         = st_reg.rd_cnt + 6'h01;
						st_next.rd_state                       = RD_IDLE;
					end
				end
			end
			default: st_next.rd_state = RD_IDLE;
		endcase
		// Write engine: buffer to destination, runs beside the read engine
		case (st_reg.wr_state)
			WR_IDLE: begin
				if (st_reg.busy && st_reg.wr_cnt != `TCD_BURSTS &&
					st_reg.full_flags[st_reg.wr_cnt[4:0]]) begin
					st_next.wr_port           = dst_port;
					st_next.awvalid[dst_port] = 1'b1;
					st_next.awaddr = (dst_port == `TCD_PORT_HST ? st_reg.host_addr
						: st_reg.ddr_addr) + (32'(st_reg.wr_cnt) << `TCD_BURST_SHIFT);
					st_next.wr_beat           = 4'h0;
					st_next.wr_state          = WR_ADDR;
				end
			end
			WR_ADDR: begin
				if (aw_ready[st_reg.wr_port]) begin
					st_next.awvalid[st_reg.wr_port] = 1'b0;
					st_next.wr_state                = WR_FETCH;
				end
			end
			WR_FETCH: st_next.wr_state = WR_LOAD;
			WR_LOAD: begin
				st_next.wdata                  = ram_rdata;
				st_next.wlast                  = (st_reg.wr_beat == `TCD_LAST_BEAT);
				st_next.wvalid[st_reg.wr_port] = 1'b1;
				st_next.wr_state               = WR_BEAT;
			end
			WR_BEAT: begin
				if (w_ready[st_reg.wr_port]) begin
					st_next.wvalid[st_reg.wr_port] = 1'b0;
					st_next.wlast                  = 1'b0;
					st_next.wr_beat                = st_reg.wr_beat + 4'h1;
					st_next.bready[st_reg.wr_port] = st_reg.wlast;
					st_next.wr_state = st_reg.wlast ? WR_RESP : WR_FETCH;
				end
			end
			WR_RESP: begin
				if (b_valid[st_reg.wr_port]) begin
					st_next.bready[st_reg.wr_port] = 1'b0;
					st_next.error = st_next.error | b_bad[st_reg.wr_port];
					st_next.wr_cnt   = st_reg.wr_cnt + 6'h01;
					st_next.wr_state = WR_IDLE;
				end
			end
			default: st_next.wr_state = WR_IDLE;
		endcase
	end
	always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	tcd_buffer_ram tcd_buffer_ram_i (
		.clk_in    (REF_CLK_IN),
		.we_in     (ram_we),
		.waddr_in  (ram_waddr),
		.wdata_in  (r_word),
		.raddr_in  (ram_raddr),
		.rdata_out (ram_rdata)
	);
	assign PRDATA_OUT  = st_reg.prdata;
	assign PREADY_OUT  = st_reg.pready;
	assign PSLVERR_OUT = st_reg.pslverr;
	assign {HST_ARADDR_OUT, MEM_ARADDR_OUT} = {2{st_reg.araddr}};
	assign {HST_AWADDR_OUT, MEM_AWADDR_OUT} = {2{st_reg.awaddr}};
	assign {HST_WDATA_OUT, MEM_WDATA_OUT}   = {2{st_reg.wdata}};
	assign {HST_WSTRB_OUT, MEM_WSTRB_OUT}   = {2{st_reg.wstrb}};
	assign {HST_WLAST_OUT, MEM_WLAST_OUT}   = {2{st_reg.wlast}};
	assign {HST_ARLEN_OUT, MEM_ARLEN_OUT, HST_AWLEN_OUT, MEM_AWLEN_OUT} = {4{st_reg.axlen}};
	assign {HST_ARSIZE_OUT, MEM_ARSIZE_OUT, HST_AWSIZE_OUT, MEM_AWSIZE_OUT} = {4{st_reg.axsize}};
	assign {HST_ARBURST_OUT, MEM_ARBURST_OUT, HST_AWBURST_OUT, MEM_AWBURST_OUT} = {4{st_reg.axburst}};
	assign {MEM_ARVALID_OUT, HST_ARVALID_OUT} = st_reg.arvalid;
	assign {MEM_RREADY_OUT, HST_RREADY_OUT}   = st_reg.rready;
	assign {MEM_AWVALID_OUT, HST_AWVALID_OUT} = st_reg.awvalid;
	assign {MEM_WVALID_OUT, HST_WVALID_OUT}   = st_reg.wvalid;
	assign {MEM_BREADY_OUT, HST_BREADY_OUT}   = st_reg.bready;

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	rd_burst_len_a: assert property ((HST_ARVALID_OUT || MEM_ARVALID_OUT) |->
		HST_ARLEN_OUT == `TCD_AXLEN && MEM_ARLEN_OUT == `TCD_AXLEN)
		else $error("read burst length is not 16 beats");
	rd_host_route_a: assert property (HST_ARVALID_OUT |->
		st_reg.mode == MODE_HOST_TO_BUF || st_reg.mode == MODE_HOST_TO_MEM)
		else $error("host read issued outside channel 0 modes");
	rd_mem_route_a: assert property (MEM_ARVALID_OUT |->
		st_reg.mode == MODE_MEM_TO_HOST || st_reg.mode == MODE_MEM_TO_BUF)
		else $error("memory read issued outside channel 1 modes");
	wr_mem_route_a: assert property (MEM_AWVALID_OUT |->
		st_reg.mode == MODE_HOST_TO_MEM || st_reg.mode == MODE_BUF_TO_MEM)
		else $error("memory write issued in wrong mode");
	wr_host_route_a: assert property (HST_AWVALID_OUT |->
		st_reg.mode == MODE_BUF_TO_HOST || st_reg.mode == MODE_MEM_TO_HOST)
		else $error("host write issued in wrong mode");
	one_port_a: assert property (!(HST_ARVALID_OUT && MEM_ARVALID_OUT) &&
		!(HST_AWVALID_OUT && MEM_AWVALID_OUT))
		else $error("both ports driven at once");
	empty_gate_a: assert property ($rose(HST_AWVALID_OUT || MEM_AWVALID_OUT) |->
		st_reg.full_flags[5'(st_reg.wr_cnt)])
		else $error("write burst started from empty chunk");
	wlast_beat_a: assert property ((HST_WVALID_OUT || MEM_WVALID_OUT) |->
		HST_WLAST_OUT == (st_reg.wr_beat == `TCD_LAST_BEAT))
		else $error("write last not on beat 16");
	chunk_fill_a: assert property ((st_reg.rd_state == RD_DATA && ram_we &&
		st_reg.rd_beat == `TCD_LAST_BEAT) |=> st_reg.full_flags[5'($past(st_reg.rd_cnt))])
		else $error("filled chunk not marked");
	timer_start_a: assert property ($rose(st_reg.busy) |-> st_reg.cycles == `TCD_ZERO32 ##1
		st_reg.cycles == 32'h0000_0001)
		else $error("timer did not start with transfer");
	timer_hold_a: assert property ((!st_reg.busy && $past(!st_reg.busy)) |->
		st_reg.cycles == $past(st_reg.cycles))
		else $error("timer changed while idle");
	done_all_a: assert property ($rose(st_reg.done) |->
		$past(st_reg.rd_cnt) == `TCD_BURSTS && $past(st_reg.wr_cnt) == `TCD_BURSTS)
		else $error("done before all 4 KB moved");
	overlap_c: cover property (st_reg.rd_state == RD_DATA && st_reg.wr_state == WR_BEAT);
	h2m_done_c: cover property ($rose(st_reg.done) && st_reg.mode == MODE_HOST_TO_MEM);
	m2h_done_c: cover property ($rose(st_reg.done) && st_reg.mode == MODE_MEM_TO_HOST);
	b2m_done_c: cover property ($rose(st_reg.done) && st_reg.mode == MODE_BUF_TO_MEM);
endmodule : tcd_dma_top
`default_nettype wire

// >>> test/tcd_axi_slave_model.sv
// Purpose: AXI slave model for the host port or the memory port
// Assumes: One read and one write burst outstanding at a time
// Notes:   Read beats carry TAG and the beat byte address
`timescale 1ns/1ps
`default_nettype none
module tcd_axi_slave_model #(
	parameter logic [31:0] TAG = 32'h0000_0001
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        slow_in,
	input  wire logic        err_in,
	input  wire logic [31:0] araddr_in,
	input  wire logic        arvalid_in,
	output var  logic        arready_out,
	output var  logic [63:0] rdata_out,
	output var  logic [1:0]  rresp_out,
	output var  logic        rlast_out,
	output var  logic        rvalid_out,
	input  wire logic        rready_in,
	input  wire logic        awvalid_in,
	output var  logic        awready_out,
	input  wire logic [63:0] wdata_in,
	input  wire logic        wlast_in,
	input  wire logic        wvalid_in,
	output var  logic        wready_out,
	output var  logic [1:0]  bresp_out,
	output var  logic        bvalid_out,
	input  wire logic        bready_in,
	output var  logic [15:0] rbursts_out,
	output var  logic [15:0] wbeats_out,
	output var  logic [63:0] wlast_data_out
);
	logic        tick;
	logic        rbusy;
	logic [3:0]  beat;
	logic [31:0] ra;
	logic        go;
	assign go          = ~slow_in | tick;
	assign arready_out = arvalid_in & ~rbusy & go;
	assign rvalid_out  = rbusy;
	assign rlast_out   = rbusy & (beat == 4'hF);
	// Idle data bus shows the inverse so stale beats never look valid
	assign rdata_out   = rbusy ? {TAG, ra + {24'h00_0000, beat, 3'h0}} : ~{TAG, ra};
	assign rresp_out   = err_in ? 2'h2 : 2'h0;
	assign bresp_out   = rresp_out;
	assign awready_out = awvalid_in & go;
	assign wready_out  = wvalid_in & go;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick        <= 1'b0;
			rbusy       <= 1'b0;
			beat        <= 4'h0;
			bvalid_out  <= 1'b0;
			rbursts_out <= 16'h0000;
			wbeats_out  <= 16'h0000;
		end else begin
			tick <= ~tick;
			if (arready_out) begin
				rbusy       <= 1'b1;
				ra          <= araddr_in;
				beat        <= 4'h0;
				rbursts_out <= rbursts_out + 16'h0001;
			end else if (rbusy && rready_in) begin
				beat  <= beat + 4'h1;
				rbusy <= ~rlast_out;
			end
			if (wready_out) begin
				wbeats_out     <= wbeats_out + 16'h0001;
				wlast_data_out <= wdata_in;
				bvalid_out     <= wlast_in;
			end else if (bready_in) begin
				bvalid_out <= 1'b0;
			end
		end
	end
endmodule : tcd_axi_slave_model
`default_nettype wire

// >>> test/tcd_dma_top_tb.sv
// Purpose: Self-checking bench of the two channel burst DMA engine
// Assumes: APB master here, AXI slave models on both ports
// Notes:   Each transfer uses its own base so stale data shows
`timescale 1ns/1ps
`default_nettype none
module tcd_dma_top_tb;
	logic        REF_CLK_IN, NRST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT;
	logic [11:0] PADDR_IN;
	logic [31:0] PWDATA_IN, PRDATA_OUT, HST_ARADDR_OUT, HST_AWADDR_OUT;
	logic [31:0] MEM_ARADDR_OUT, MEM_AWADDR_OUT;
	logic [7:0]  HST_ARLEN_OUT, HST_AWLEN_OUT, MEM_ARLEN_OUT, MEM_AWLEN_OUT;
	logic [7:0]  HST_WSTRB_OUT, MEM_WSTRB_OUT;
	logic [2:0]  HST_ARSIZE_OUT, HST_AWSIZE_OUT, MEM_ARSIZE_OUT, MEM_AWSIZE_OUT;
	logic [1:0]  HST_ARBURST_OUT, HST_AWBURST_OUT, MEM_ARBURST_OUT, MEM_AWBURST_OUT;
	logic [1:0]  HST_RRESP_IN, HST_BRESP_IN, MEM_RRESP_IN, MEM_BRESP_IN;
	logic [63:0] HST_RDATA_IN, HST_WDATA_OUT, MEM_RDATA_IN, MEM_WDATA_OUT;
	logic        HST_ARVALID_OUT, HST_ARREADY_IN, HST_RLAST_IN, HST_RVALID_IN, HST_RREADY_OUT;
	logic        HST_AWVALID_OUT, HST_AWREADY_IN, HST_WLAST_OUT, HST_WVALID_OUT, HST_WREADY_IN;
	logic        MEM_ARVALID_OUT, MEM_ARREADY_IN, MEM_RLAST_IN, MEM_RVALID_IN, MEM_RREADY_OUT;
	logic        MEM_AWVALID_OUT, MEM_AWREADY_IN, MEM_WLAST_OUT, MEM_WVALID_OUT, MEM_WREADY_IN;
	logic        HST_BVALID_IN, HST_BREADY_OUT, MEM_BVALID_IN, MEM_BREADY_OUT;
	logic        hst_slow, mem_slow, hst_err, mem_err, perr;
	logic [15:0] hst_rb, hst_wb, mem_rb, mem_wb;
	logic [63:0] hst_wd, mem_wd;
	int          bad_count, compares;

	tcd_dma_top tcd_dma_top_i (.*);
	tcd_axi_slave_model #(.TAG(32'h0000_0001)) tcd_axi_slave_model_hst_i (
		.clk_in(REF_CLK_IN), .rst_n_in(NRST_IN), .slow_in(hst_slow), .err_in(hst_err),
		.araddr_in(HST_ARADDR_OUT), .arvalid_in(HST_ARVALID_OUT), .arready_out(HST_ARREADY_IN),
		.rdata_out(HST_RDATA_IN), .rresp_out(HST_RRESP_IN), .rlast_out(HST_RLAST_IN),
		.rvalid_out(HST_RVALID_IN), .rready_in(HST_RREADY_OUT), .awvalid_in(HST_AWVALID_OUT),
		.awready_out(HST_AWREADY_IN), .wdata_in(HST_WDATA_OUT), .wlast_in(HST_WLAST_OUT),
		.wvalid_in(HST_WVALID_OUT), .wready_out(HST_WREADY_IN), .bresp_out(HST_BRESP_IN),
		.bvalid_out(HST_BVALID_IN), .bready_in(HST_BREADY_OUT), .rbursts_out(hst_rb),
		.wbeats_out(hst_wb), .wlast_data_out(hst_wd));
	tcd_axi_slave_model #(.TAG(32'h0000_0002)) tcd_axi_slave_model_mem_i (
		.clk_in(REF_CLK_IN), .rst_n_in(NRST_IN), .slow_in(mem_slow), .err_in(mem_err),
		.araddr_in(MEM_ARADDR_OUT), .arvalid_in(MEM_ARVALID_OUT), .arready_out(MEM_ARREADY_IN),
		.rdata_out(MEM_RDATA_IN), .rresp_out(MEM_RRESP_IN), .rlast_out(MEM_RLAST_IN),
		.rvalid_out(MEM_RVALID_IN), .rready_in(MEM_RREADY_OUT), .awvalid_in(MEM_AWVALID_OUT),
		.awready_out(MEM_AWREADY_IN), .wdata_in(MEM_WDATA_OUT), .wlast_in(MEM_WLAST_OUT),
		.wvalid_in(MEM_WVALID_OUT), .wready_out(MEM_WREADY_IN), .bresp_out(MEM_BRESP_IN),
		.bvalid_out(MEM_BVALID_IN), .bready_in(MEM_BREADY_OUT), .rbursts_out(mem_rb),
		.wbeats_out(mem_wb), .wlast_data_out(mem_wd));

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer, entered and left just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		PSEL_IN   <= 1'b1;
		PWRITE_IN <= wr;
		PADDR_IN  <= a;
		PWDATA_IN <= d;
		@(posedge REF_CLK_IN);
		PENABLE_IN <= 1'b1;
		n = 0;
		do begin
			@(posedge REF_CLK_IN);
			n++;
		end while (PREADY_OUT !== 1'b1 && n < 20);
		chk(PREADY_OUT, 64'h1);
		q = PRDATA_OUT;
		perr = PSLVERR_OUT;
		PSEL_IN    <= 1'b0;
		PENABLE_IN <= 1'b0;
		@(posedge REF_CLK_IN);
	endtask : apb

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	always @(posedge REF_CLK_IN) begin
		if (MEM_AWVALID_OUT) chk({MEM_AWLEN_OUT, MEM_AWSIZE_OUT, MEM_AWBURST_OUT}, 13'h01ED);
		if (HST_AWVALID_OUT) chk({HST_AWLEN_OUT, HST_AWSIZE_OUT, HST_AWBURST_OUT}, 13'h01ED);
		if (HST_ARVALID_OUT) chk({HST_ARLEN_OUT, HST_ARSIZE_OUT, HST_ARBURST_OUT}, 13'h01ED);
		if (MEM_ARVALID_OUT) chk({MEM_ARLEN_OUT, MEM_ARSIZE_OUT, MEM_ARBURST_OUT}, 13'h01ED);
		if (HST_WVALID_OUT || MEM_WVALID_OUT) chk({HST_WSTRB_OUT, MEM_WSTRB_OUT}, 64'hFFFF);
	end

	initial begin
		REF_CLK_IN = 1'b0;
		forever #2 REF_CLK_IN = ~REF_CLK_IN;
	end

	initial begin
		repeat (30000) @(posedge REF_CLK_IN);
		bad_count++;
		end_sim;
	end

	initial begin
		logic [31:0] q;
		logic [31:0] c;
		logic [31:0] base;
		logic [15:0] hr, hw, mr, mw;
		int          n;
		bad_count = 0;
		compares = 0;
		{NRST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} = '0;
		{hst_slow, mem_slow, hst_err, mem_err} = 4'h0;
		repeat (2) @(posedge REF_CLK_IN);
		NRST_IN <= 1'b1;
		@(posedge REF_CLK_IN);
		apb(1'b0, 12'h00C, 32'h0000_0000, q);
		chk(q, 64'h0);
		apb(1'b0, 12'h010, 32'h0000_0000, q);
		chk(q, 64'h0);
		apb(1'b0, 12'h014, 32'h0000_0000, q);
		chk({perr, q}, 64'h1_0000_0000);
		apb(1'b1, 12'h000, 32'h0000_0007, q);
		apb(1'b0, 12'h000, 32'h0000_0000, q);
		chk(q, 64'h0);
		// Pass 6 repeats the last mode with error responses from memory
		for (int m = 0; m < 7; m++) begin
			base = {16'(m + 1), 16'h0000};
			hst_slow <= (m == 1);
			mem_slow <= (m == 4);
			mem_err  <= (m == 6);
			{hr, hw, mr, mw} = {hst_rb, hst_wb, mem_rb, mem_wb};
			apb(1'b1, 12'h004, base, q);
			apb(1'b1, 12'h008, base, q);
			apb(1'b1, 12'h000, (m == 6) ? 32'h0000_0005 : 32'(m), q);
			apb(1'b1, 12'h000, 32'h0000_0100, q);
			apb(1'b0, 12'h00C, 32'h0000_0000, q);
			chk(q, (m >= 3) ? 64'h9 : 64'h1);
			n = 0;
			do begin
				apb(1'b0, 12'h00C, 32'h0000_0000, q);
				n++;
			end while (q[1] !== 1'b1 && n < 3000);
			chk(q, ((m >= 3) ? 64'hA : 64'h2) | ((m == 6) ? 64'h4 : 64'h0));
			apb(1'b0, 12'h010, 32'h0000_0000, c);
			chk(c >= 32'h0000_0200, 64'h1);
			apb(1'b0, 12'h010, 32'h0000_0000, q);
			chk(q, c);
			chk((32'h0000_1000 / c) <= 32'h0000_0008, 64'h1);
			apb(1'b0, 12'h000, 32'h0000_0000, q);
			chk(q, (m == 6) ? 64'h5 : 64'(m));
			chk(hst_rb - hr, (m < 2) ? 64'h20 : 64'h0);
			chk(mem_rb - mr, (m > 3) ? 64'h20 : 64'h0);
			chk(mem_wb - mw, (m == 1 || m == 2) ? 64'h200 : 64'h0);
			chk(hst_wb - hw, (m == 3 || m == 4) ? 64'h200 : 64'h0);
			if (m == 1 || m == 2) chk(mem_wd, 64'h0000_0001_0002_0FF8);
			if (m == 3) chk(hst_wd, 64'h0000_0001_0002_0FF8);
			if (m == 4) chk(hst_wd, 64'h0000_0002_0005_0FF8);
			$display("test %0d done", m);
		end
		end_sim;
	end
endmodule : tcd_dma_top_tb
`default_nettype wire
